// ### inc/cksc_defs.svh
`ifndef CKSC_DEFS_SVH
`define CKSC_DEFS_SVH

// System clock rate in MHz.
`define CKSC_CLK_MHZ 125
// Oscillator enables after reset: only the ultra low power oscillator.
`define CKSC_OSC_EN_RST 7'h40
// Dividers that turn 32 kHz and 32.768 kHz into 1 kHz and 1.024 kHz.
`define CKSC_DIV32_M1 5'h1F
// Prescaler: log2 of the largest division ratio, 2048.
`define CKSC_PSC_LOG_MAX 4'hB
`define CKSC_PSC_RST 4'h0
// Multiplier limits and reset value.
`define CKSC_PLL_FAC_MIN 5'h01
`define CKSC_PLL_FAC_MAX 5'h1F
`define CKSC_PLL_FAC_RST 5'h01
// Silence on a running crystal that counts as a failure, in microseconds.
`define CKSC_FAIL_US 64
`define CKSC_FAIL_CYC (`CKSC_FAIL_US * `CKSC_CLK_MHZ)
// Calibrator targets: oscillator edges per 32.768 kHz reference period.
`define CKSC_FREQ_LOCK_CALIBRATOR_TGT_2M 11'h03D
`define CKSC_FREQ_LOCK_CALIBRATOR_TGT_32M 11'h3D1
`define CKSC_CNT_SAT 11'h7FF
// Synchronised vector width: three crystals/clocks, four internal, port C, seven ready flags.
`define CKSC_SYNC_W 22

`endif

// ### inc/cksc_pkg.sv
package cksc_pkg;

  // One bit per clock source.
  typedef struct packed {
    logic ultra_low_power_osc;
    logic lfx;
    logic rc32k;
    logic pll;
    logic xosc;
    logic rc32m;
    logic rc2m;
  } cksc_osc_t;

  typedef enum logic [2:0] {
    SRC_RC2M, SRC_RC32M, SRC_RC32K, SRC_XOSC, SRC_PLL, SRC_LFX
  } cksc_src_t;

  typedef enum logic [1:0] {REF_RC2M, REF_RC32M, REF_XOSC} cksc_pll_ref_t;

  typedef enum logic [1:0] {RTC_ULP, RTC_RC32K, RTC_LFX} cksc_rtc_src_t;

  typedef struct packed {
    logic pll;
    logic xosc;
  } cksc_fail_t;

  // Calibration bytes: [2] 32.768 kHz, [1] 32 MHz, [0] 2 MHz.
  typedef logic [2:0][7:0] cksc_cal_t;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_SWAP} cksc_sw_st_t;

endpackage : cksc_pkg

// ### core/cksc_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pins that come from other clocks.
module cksc_sync #(
  parameter int W = 1
) (
  input logic clock,
  input logic reset,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // The first stage is read only by the second.
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : cksc_sync

// ### core/cksc_div.sv
`timescale 1ns/1ns
// Tick divider: one output pulse per ratio_m1 + 1 input ticks.
module cksc_div #(
  parameter int W = 11
) (
  input logic clock,
  input logic reset,
  input logic restart,
  input logic tick_in,
  input logic [W-1:0] ratio_m1,
  output logic tick_out
);
  logic [W-1:0] cnt_q;

  // A restart drops the partial count so no short first period escapes.
  always_ff @(posedge clock) begin
    if (reset || restart) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_q >= ratio_m1) begin
          cnt_q <= '0;
          tick_out <= 1'b1;
        end else begin
          cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : cksc_div

// ### core/cksc_ctrl.sv
`timescale 1ns/1ns
`include "cksc_defs.svh"
// Operation
// [R1] Reset leaves only ultra low power oscillator on.
// [R2] Execution starts from 2 MHz oscillator.
// [R3] Other sources, calibrators, multiplier stay off.
// [R4] Software may change source and prescaler anytime.
// [R5] Source switching never emits truncated ticks.
// [R6] Monitor failure: interrupt and fall back internally.
// [R7] Detect crystal and lock failure; interrupt optional.
// [R8] Ultra low power oscillator gives 1 kHz.
// [R9] Ultra low power oscillator on when used.
// [R10] 32.768 kHz oscillator gives 1.024 kHz too.
// [R11] 32.768 kHz calibration loads, software may overwrite.
// [R12] 32 kHz sources serve system, counter, calibrators.
// [R13] Main crystal has four range modes.
// [R14] Calibrators trim 2 MHz and 32 MHz oscillators.
// [R15] 32 MHz calibration spans 30 to 55 MHz.
// [R16] Stored 48 MHz calibration for USB use.
// [R17] External clock from crystal pin or port C.
// [R18] Multiplier factor is 1 to 31.
// [R19] Prescaler divides 1 to 2048.
// [R20] Fast peripheral ticks at 2x, 4x CPU.
// [R21] Switch waits for enabled, ready target source.
module cksc_ctrl #(
  parameter int FAIL_CYC = `CKSC_FAIL_CYC,
  parameter logic [7:0] USB_CAL = 8'h80
) (
  input logic clock,
  input logic reset,
  input logic rc2m_osc,
  input logic rc32m_osc,
  input logic rc32k_osc,
  input logic ulp_osc,
  input logic pll_osc,
  input logic low_freq_crystal_in,
  input logic main_crystal_in,
  input logic [7:0] portc_in,
  input cksc_pkg::cksc_osc_t osc_ready,
  input logic ulp_req,
  input cksc_pkg::cksc_osc_t sw_osc_en,
  input cksc_pkg::cksc_src_t sw_src_sel,
  input logic [3:0] sw_psc_log,
  input logic [4:0] sw_pll_fac,
  input cksc_pkg::cksc_pll_ref_t sw_pll_ref,
  input logic [1:0] sw_xosc_mode,
  input logic sw_ext_pin_sel,
  input logic [2:0] sw_portc_sel,
  input logic sw_mon_en,
  input logic sw_nmi_en,
  input cksc_pkg::cksc_fail_t sw_fail_clr,
  input logic [1:0] sw_freq_lock_calibrator_en,
  input logic sw_freq_lock_calibrator_ref,
  input logic [2:0] sw_cal_we,
  input logic [7:0] sw_cal_wdata,
  input logic sw_usb_cal_ld,
  input cksc_pkg::cksc_cal_t prod_cal,
  input logic rtc_en,
  input cksc_pkg::cksc_rtc_src_t rtc_src,
  output cksc_pkg::cksc_osc_t osc_en_q,
  output cksc_pkg::cksc_src_t cur_src_q,
  output logic switching_q,
  output logic switch_refused_q,
  output logic cpu_tick_q,
  output logic per2_tick_q,
  output logic per4_tick_q,
  output logic ulp_1k_q,
  output logic rc32k_1k_q,
  output logic rtc_tick_q,
  output logic [3:0] psc_log_q,
  output logic [4:0] pll_fac_q,
  output cksc_pkg::cksc_pll_ref_t pll_ref_q,
  output logic [1:0] xosc_mode_q,
  output logic ext_pin_sel_q,
  output logic [2:0] portc_sel_q,
  output cksc_pkg::cksc_fail_t fail_q,
  output logic nmi_q,
  output logic [1:0] freq_lock_calibrator_en_q,
  output cksc_pkg::cksc_cal_t cal_q
);

  // Picks the bit of a per-source vector that belongs to one source.
  function automatic logic src_bit(input cksc_pkg::cksc_src_t s,
                                   input cksc_pkg::cksc_osc_t v);
    case (s)
      cksc_pkg::SRC_RC2M: src_bit = v.rc2m;
      cksc_pkg::SRC_RC32M: src_bit = v.rc32m;
      cksc_pkg::SRC_RC32K: src_bit = v.rc32k;
      cksc_pkg::SRC_XOSC: src_bit = v.xosc;
      cksc_pkg::SRC_PLL: src_bit = v.pll;
      cksc_pkg::SRC_LFX: src_bit = v.lfx;
      default: src_bit = 1'b0;
    endcase
  endfunction : src_bit

  // One-hot enable vector for one source.
  function automatic cksc_pkg::cksc_osc_t src_set(input cksc_pkg::cksc_src_t s);
    src_set = '0;
    case (s)
      cksc_pkg::SRC_RC2M: src_set.rc2m = 1'b1;
      cksc_pkg::SRC_RC32M: src_set.rc32m = 1'b1;
      cksc_pkg::SRC_RC32K: src_set.rc32k = 1'b1;
      cksc_pkg::SRC_XOSC: src_set.xosc = 1'b1;
      cksc_pkg::SRC_PLL: src_set.pll = 1'b1;
      cksc_pkg::SRC_LFX: src_set.lfx = 1'b1;
      default: src_set = '0;
    endcase
  endfunction : src_set

  logic [`CKSC_SYNC_W-1:0] raw;
  logic [`CKSC_SYNC_W-1:0] sync_s;
  logic [`CKSC_SYNC_W-1:0] prev_q;
  logic [`CKSC_SYNC_W-1:0] edge_w;
  cksc_pkg::cksc_osc_t tick;
  cksc_pkg::cksc_osc_t rdy;
  cksc_pkg::cksc_osc_t rdy_prev;
  cksc_pkg::cksc_osc_t osc_en_d;
  cksc_pkg::cksc_src_t tgt_q;
  cksc_pkg::cksc_sw_st_t st_q;
  cksc_pkg::cksc_fail_t fail_evt;
  cksc_pkg::cksc_src_t pll_ref_src;
  logic [15:0] xosc_idle_q;
  logic xosc_used;
  logic fallback;
  logic sel_blocked;
  logic tgt_blocked;
  logic psc_tick;
  logic [1:0] phase_q;
  logic freq_lock_calibrator_ref_tick;
  logic [2:0] cal_tick;
  logic [2:0] freq_lock_calibrator_act;
  logic [2:0][10:0] cnt_q;
  logic [2:0][10:0] tgt_cnt;

  // Every pin is another clock's signal, so all of them are synchronised.
  assign raw = {osc_ready, portc_in, main_crystal_in, low_freq_crystal_in, pll_osc,
                ulp_osc, rc32k_osc, rc32m_osc, rc2m_osc};

  cksc_sync #(
    .W(`CKSC_SYNC_W)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .d(raw),
    .q(sync_s)
  );

  // Rising-edge history of the synchronised pins.
  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= '0;
    end else begin
      prev_q <= sync_s;
    end
  end

  // Oscillator edges become single-cycle ticks; sources above 62.5 MHz alias.
  assign edge_w = sync_s & ~prev_q;
  assign rdy = sync_s[21:15];
  assign rdy_prev = prev_q[21:15];
  assign tick.rc2m = edge_w[0];
  assign tick.rc32m = edge_w[1];
  assign tick.rc32k = edge_w[2];
  assign tick.ultra_low_power_osc = edge_w[3];
  assign tick.pll = edge_w[4];
  assign tick.lfx = edge_w[5];
  assign tick.xosc = ext_pin_sel_q ? edge_w[7 + portc_sel_q] : edge_w[6]; // see [R17]

  assign pll_ref_src = (pll_ref_q == cksc_pkg::REF_RC32M) ? cksc_pkg::SRC_RC32M :
                       (pll_ref_q == cksc_pkg::REF_XOSC) ? cksc_pkg::SRC_XOSC :
                       cksc_pkg::SRC_RC2M;

  // Enables: software bits, with ulp_req in place of the ultra low power one, plus whatever is in use right now.
  always_comb begin
    osc_en_d = sw_osc_en;
    osc_en_d.ultra_low_power_osc = ulp_req || (rtc_en && rtc_src == cksc_pkg::RTC_ULP); // see [R9]
    osc_en_d.rc32k = sw_osc_en.rc32k || (rtc_en && rtc_src == cksc_pkg::RTC_RC32K) ||
                     ((|freq_lock_calibrator_en_q) && !sw_freq_lock_calibrator_ref); // see [R12]
    osc_en_d.lfx = sw_osc_en.lfx || (rtc_en && rtc_src == cksc_pkg::RTC_LFX) ||
                   ((|freq_lock_calibrator_en_q) && sw_freq_lock_calibrator_ref); // see [R12]
    osc_en_d = osc_en_d | src_set(cur_src_q);
    if (osc_en_d.pll) begin
      osc_en_d = osc_en_d | src_set(pll_ref_src);
    end
  end

  // The ultra low power oscillator is the only source left on in reset.
  always_ff @(posedge clock) begin
    if (reset) begin
      osc_en_q <= `CKSC_OSC_EN_RST; // see [R1] [R3]
    end else begin
      osc_en_q <= osc_en_d;
    end
  end

  // Setup; multiplier and crystal fields change only while that consumer is off, the prescaler anytime.
  always_ff @(posedge clock) begin
    if (reset) begin
      pll_fac_q <= `CKSC_PLL_FAC_RST;
      pll_ref_q <= cksc_pkg::REF_RC2M;
      xosc_mode_q <= 2'h0;
      ext_pin_sel_q <= 1'b0;
      portc_sel_q <= 3'h0;
      psc_log_q <= `CKSC_PSC_RST;
    end else begin
      if (!osc_en_q.pll && sw_pll_fac >= `CKSC_PLL_FAC_MIN) begin
        pll_fac_q <= sw_pll_fac; // see [R18]
        pll_ref_q <= sw_pll_ref;
      end
      if (!osc_en_q.xosc) begin
        xosc_mode_q <= sw_xosc_mode; // see [R13]
        ext_pin_sel_q <= sw_ext_pin_sel; // see [R17]
        portc_sel_q <= sw_portc_sel;
      end
      if (sw_psc_log <= `CKSC_PSC_LOG_MAX) begin
        psc_log_q <= sw_psc_log; // see [R4] [R19]
      end
    end
  end

  // Crystal silence counter; it only runs while the crystal claims ready.
  always_ff @(posedge clock) begin
    if (reset) begin
      xosc_idle_q <= 16'h0000;
    end else if (tick.xosc || !osc_en_q.xosc || !rdy.xosc) begin
      xosc_idle_q <= 16'h0000;
    end else if (xosc_idle_q != 16'(FAIL_CYC)) begin
      xosc_idle_q <= xosc_idle_q + 16'h0001;
    end
  end

  // Failure events fire once: at the silence limit or on loss of lock.
  assign fail_evt.xosc = sw_mon_en && xosc_idle_q == 16'(FAIL_CYC - 1); // see [R7]
  assign fail_evt.pll = sw_mon_en && osc_en_q.pll && rdy_prev.pll && !rdy.pll; // see [R7]
  assign xosc_used = cur_src_q == cksc_pkg::SRC_XOSC ||
                     (cur_src_q == cksc_pkg::SRC_PLL && pll_ref_q == cksc_pkg::REF_XOSC);
  assign fallback = (fail_evt.xosc && xosc_used) ||
                    (fail_evt.pll && cur_src_q == cksc_pkg::SRC_PLL); // see [R6]

  // Sticky failure flags; a new event beats a clear in the same cycle.
  always_ff @(posedge clock) begin
    if (reset) begin
      fail_q <= '0;
      nmi_q <= 1'b0;
    end else begin
      fail_q <= (fail_q & ~sw_fail_clr) | fail_evt; // see [R6]
      nmi_q <= sw_nmi_en && (|fail_evt); // see [R7]
    end
  end

  // A source is refused while off, or while its failure flag stands.
  assign sel_blocked = !src_bit(sw_src_sel, osc_en_q) ||
                       (sw_src_sel == cksc_pkg::SRC_XOSC && fail_q.xosc) ||
                       (sw_src_sel == cksc_pkg::SRC_PLL && fail_q.pll);
  assign tgt_blocked = !src_bit(tgt_q, osc_en_q) ||
                       (tgt_q == cksc_pkg::SRC_XOSC && fail_q.xosc) ||
                       (tgt_q == cksc_pkg::SRC_PLL && fail_q.pll);

  // Switcher: the old source runs until the new one is ready, then one
  // dead cycle restarts the prescaler so no partial period is delivered.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= cksc_pkg::ST_RUN;
      cur_src_q <= cksc_pkg::SRC_RC2M; // see [R2]
      tgt_q <= cksc_pkg::SRC_RC2M;
      switching_q <= 1'b0;
      switch_refused_q <= 1'b0;
    end else if (fallback) begin
      st_q <= cksc_pkg::ST_RUN;
      cur_src_q <= cksc_pkg::SRC_RC2M; // see [R6]
      switching_q <= 1'b0;
      switch_refused_q <= 1'b0;
    end else begin
      switch_refused_q <= 1'b0;
      case (st_q)
        cksc_pkg::ST_RUN: begin
          if (sw_src_sel != cur_src_q) begin
            if (sel_blocked) begin
              switch_refused_q <= 1'b1; // see [R21]
            end else begin
              tgt_q <= sw_src_sel; // see [R4]
              st_q <= cksc_pkg::ST_WAIT;
              switching_q <= 1'b1;
            end
          end
        end
        cksc_pkg::ST_WAIT: begin
          if (sw_src_sel != tgt_q || tgt_blocked) begin
            st_q <= cksc_pkg::ST_RUN;
            switching_q <= 1'b0;
          end else if (src_bit(tgt_q, rdy)) begin
            st_q <= cksc_pkg::ST_SWAP; // see [R21]
          end
        end
        cksc_pkg::ST_SWAP: begin
          cur_src_q <= tgt_q; // see [R5]
          st_q <= cksc_pkg::ST_RUN;
          switching_q <= 1'b0;
        end
        default: begin
          st_q <= cksc_pkg::ST_RUN;
          switching_q <= 1'b0;
        end
      endcase
    end
  end

  // Prescaler counts ticks of the current source only outside the swap.
  cksc_div #(
    .W(11)
  ) u_psc (
    .clock(clock),
    .reset(reset),
    .restart(st_q == cksc_pkg::ST_SWAP || fallback), // see [R5]
    .tick_in(src_bit(cur_src_q, tick)),
    .ratio_m1(11'((12'h001 << psc_log_q) - 12'h001)), // see [R19]
    .tick_out(psc_tick)
  );

  // The 4x tick is the prescaler output; 2x and CPU ticks are aligned
  // subsets of it, so all three share their rising moments.
  always_ff @(posedge clock) begin
    if (reset || st_q == cksc_pkg::ST_SWAP || fallback) begin
      phase_q <= 2'h0;
      per4_tick_q <= 1'b0;
      per2_tick_q <= 1'b0;
      cpu_tick_q <= 1'b0;
    end else begin
      if (psc_tick) begin
        phase_q <= phase_q + 2'h1;
      end
      per4_tick_q <= psc_tick; // see [R20]
      per2_tick_q <= psc_tick && phase_q[0]; // see [R20]
      cpu_tick_q <= psc_tick && phase_q == 2'h3; // see [R20]
    end
  end

  logic ulp_1k;
  logic rc32k_1k;

  cksc_div #(
    .W(5)
  ) u_ulp_div (
    .clock(clock),
    .reset(reset),
    .restart(!osc_en_q.ultra_low_power_osc),
    .tick_in(tick.ultra_low_power_osc),
    .ratio_m1(`CKSC_DIV32_M1), // see [R8]
    .tick_out(ulp_1k)
  );

  cksc_div #(
    .W(5)
  ) u_rc32k_div (
    .clock(clock),
    .reset(reset),
    .restart(!osc_en_q.rc32k),
    .tick_in(tick.rc32k),
    .ratio_m1(`CKSC_DIV32_M1), // see [R10]
    .tick_out(rc32k_1k)
  );

  // Low rate outputs and the counter/display clock selection.
  always_ff @(posedge clock) begin
    if (reset) begin
      ulp_1k_q <= 1'b0;
      rc32k_1k_q <= 1'b0;
      rtc_tick_q <= 1'b0;
    end else begin
      ulp_1k_q <= ulp_1k;
      rc32k_1k_q <= rc32k_1k;
      case (rtc_src)
        cksc_pkg::RTC_ULP: rtc_tick_q <= rtc_en && tick.ultra_low_power_osc; // see [R9]
        cksc_pkg::RTC_RC32K: rtc_tick_q <= rtc_en && tick.rc32k; // see [R12]
        cksc_pkg::RTC_LFX: rtc_tick_q <= rtc_en && tick.lfx; // see [R12]
        default: rtc_tick_q <= 1'b0;
      endcase
    end
  end

  // A calibrator runs only while software enables it and its oscillator is on.
  always_ff @(posedge clock) begin
    if (reset) begin
      freq_lock_calibrator_en_q <= 2'h0; // see [R3]
    end else begin
      freq_lock_calibrator_en_q[0] <= sw_freq_lock_calibrator_en[0] && osc_en_q.rc2m; // see [R14]
      freq_lock_calibrator_en_q[1] <= sw_freq_lock_calibrator_en[1] && osc_en_q.rc32m; // see [R14]
    end
  end

  assign freq_lock_calibrator_ref_tick = sw_freq_lock_calibrator_ref ? tick.lfx : tick.rc32k; // see [R12]
  assign cal_tick = {tick.rc32k, tick.rc32m, tick.rc2m};
  assign freq_lock_calibrator_act = {1'b0, freq_lock_calibrator_en_q};
  assign tgt_cnt = {11'h000, `CKSC_FREQ_LOCK_CALIBRATOR_TGT_32M, `CKSC_FREQ_LOCK_CALIBRATOR_TGT_2M};

  // Calibration bytes: production value at reset, software write first,
  // then the stored USB value, then one step per reference period.
  // The 32 MHz byte spans 30 to 55 MHz over its full code range.
  always_ff @(posedge clock) begin
    if (reset) begin
      cal_q <= prod_cal; // see [R11]
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (freq_lock_calibrator_ref_tick) begin
          cnt_q[i] <= 11'h000;
        end else if (cal_tick[i] && cnt_q[i] != `CKSC_CNT_SAT) begin
          cnt_q[i] <= cnt_q[i] + 11'h001;
        end
        if (sw_cal_we[i]) begin
          cal_q[i] <= sw_cal_wdata; // see [R11] [R15]
        end else if (i == 1 && sw_usb_cal_ld) begin
          cal_q[i] <= USB_CAL; // see [R16]
        end else if (freq_lock_calibrator_act[i] && freq_lock_calibrator_ref_tick) begin
          if (cnt_q[i] < tgt_cnt[i] && cal_q[i] != 8'hFF) begin
            cal_q[i] <= cal_q[i] + 8'h01; // see [R14]
          end else if (cnt_q[i] > tgt_cnt[i] && cal_q[i] != 8'h00) begin
            cal_q[i] <= cal_q[i] - 8'h01; // see [R14]
          end
        end
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_rst_en;
    $past(reset) |-> osc_en_q == `CKSC_OSC_EN_RST;
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("reset enables wrong"); // see [R1]

  property p_rst_src;
    $past(reset) |-> cur_src_q == cksc_pkg::SRC_RC2M && freq_lock_calibrator_en_q == 2'h0;
  endproperty
  a_rst_src: assert property (p_rst_src) else $error("reset source wrong"); // see [R2] [R3]

  property p_swap_ready;
    $changed(cur_src_q) && !$past(fallback) |-> $past(src_bit(tgt_q, rdy), 2);
  endproperty
  a_swap_ready: assert property (p_swap_ready) else $error("switched to unready"); // see [R21]

  property p_swap_quiet;
    st_q == cksc_pkg::ST_SWAP |=> !per4_tick_q && !cpu_tick_q ##1 !per4_tick_q;
  endproperty
  a_swap_quiet: assert property (p_swap_quiet) else $error("tick across swap"); // see [R5]

  property p_fallback;
    fallback |=> cur_src_q == cksc_pkg::SRC_RC2M && (fail_q != 2'h0) && !switching_q;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fallback"); // see [R6]

  property p_nmi;
    (|fail_evt) |=> nmi_q == $past(sw_nmi_en);
  endproperty
  a_nmi: assert property (p_nmi) else $error("interrupt mismatch"); // see [R7]

  property p_pll_fac;
    pll_fac_q >= `CKSC_PLL_FAC_MIN && pll_fac_q <= `CKSC_PLL_FAC_MAX;
  endproperty
  a_pll_fac: assert property (p_pll_fac) else $error("factor out of range"); // see [R18]

  property p_align;
    cpu_tick_q |-> per2_tick_q && per4_tick_q;
  endproperty
  a_align: assert property (p_align) else $error("ticks misaligned"); // see [R20]

  property p_ulp_use;
    rtc_en && rtc_src == cksc_pkg::RTC_ULP |=> osc_en_q.ultra_low_power_osc;
  endproperty
  a_ulp_use: assert property (p_ulp_use) else $error("ulp not enabled"); // see [R9]

  property p_refuse;
    st_q == cksc_pkg::ST_RUN && sw_src_sel != cur_src_q && sel_blocked && !fallback
      |=> switch_refused_q && $stable(cur_src_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("blocked switch taken"); // see [R21]

  property p_c_swap;
    st_q == cksc_pkg::ST_SWAP;
  endproperty
  c_swap: cover property (p_c_swap);

  property p_c_fallback;
    fallback;
  endproperty
  c_fallback: cover property (p_c_fallback);

  property p_c_refuse;
    switch_refused_q;
  endproperty
  c_refuse: cover property (p_c_refuse);

endmodule : cksc_ctrl

// ### tb/tb_top.sv
`timescale 1ns/1ns
// Self-checking bench for the clock source controller.
module tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rc2m_osc, rc32m_osc, rc32k_osc, ulp_osc, pll_osc, low_freq_crystal_in, main_crystal_in;
  logic [7:0] portc_in, sw_cal_wdata;
  cksc_pkg::cksc_osc_t osc_ready, sw_osc_en, osc_en_q;
  logic ulp_req, sw_ext_pin_sel, sw_mon_en, sw_nmi_en, sw_freq_lock_calibrator_ref, sw_usb_cal_ld, rtc_en;
  cksc_pkg::cksc_src_t sw_src_sel, cur_src_q;
  logic [3:0] sw_psc_log, psc_log_q, ph;
  logic [4:0] sw_pll_fac, pll_fac_q;
  cksc_pkg::cksc_pll_ref_t sw_pll_ref, pll_ref_q;
  logic [1:0] sw_xosc_mode, xosc_mode_q, sw_freq_lock_calibrator_en, freq_lock_calibrator_en_q;
  logic [2:0] sw_portc_sel, portc_sel_q, sw_cal_we;
  cksc_pkg::cksc_fail_t sw_fail_clr, fail_q;
  cksc_pkg::cksc_cal_t prod_cal, cal_q;
  cksc_pkg::cksc_rtc_src_t rtc_src;
  logic switching_q, switch_refused_q, cpu_tick_q, per2_tick_q, per4_tick_q;
  logic ulp_1k_q, rc32k_1k_q, rtc_tick_q, ext_pin_sel_q, nmi_q, xtal_run;
  int err_count, total_checks, cycles, nmi_seen, n4, n2, n1;
  bit seen;

  cksc_ctrl #(.FAIL_CYC(50)) i_cksc_ctrl (.*);

  // The clock toggles every half period of 4 ns.
  always #4 clock = ~clock;

  // Oscillator waveforms are slow enough for the 125 MHz sampler to see every edge.
  always @(negedge clock) begin
    ph <= ph + 4'h1;
    rc2m_osc <= ph[2];
    rc32m_osc <= ph[1];
    rc32k_osc <= ph[2];
    ulp_osc <= ph[2];
    pll_osc <= ph[1];
    low_freq_crystal_in <= ph[3];
    main_crystal_in <= xtal_run ? ph[1] : 1'b0;
    portc_in <= {8{ph[2]}};
    if (nmi_q === 1'b1) nmi_seen++;
  end

  // A hang is cut short well beyond the expected run length.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_src(input cksc_pkg::cksc_src_t s);
    for (int k = 0; k < 40 && cur_src_q !== s; k++) cyc(1);
    chk(32'(cur_src_q), 32'(s));
  endtask : wait_src

  // Counts one-cycle pulses of a divided output over a fixed window.
  task automatic count_1k(input bit which, output int n);
    n = 0;
    repeat (1024) begin
      cyc(1);
      if ((which ? rc32k_1k_q : ulp_1k_q) === 1'b1) n++;
    end
  endtask : count_1k

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Main sequence; all inputs change at the falling edge.
  initial begin
    {ph, xtal_run, ulp_req, sw_ext_pin_sel, sw_mon_en, sw_nmi_en} = '0;
    {sw_freq_lock_calibrator_ref, sw_usb_cal_ld, rtc_en, sw_cal_wdata, sw_cal_we, sw_freq_lock_calibrator_en} = '0;
    {sw_psc_log, sw_xosc_mode, sw_portc_sel, sw_fail_clr, sw_osc_en} = '0;
    osc_ready = 7'h7F;
    sw_src_sel = cksc_pkg::SRC_RC2M;
    sw_pll_fac = 5'h01;
    sw_pll_ref = cksc_pkg::REF_RC2M;
    rtc_src = cksc_pkg::RTC_ULP;
    prod_cal = {8'hA5, 8'h3C, 8'h5A};
    cyc(9);
    chk(32'(osc_en_q), 32'h40);
    chk(32'(cur_src_q), 32'(cksc_pkg::SRC_RC2M));
    chk({pll_fac_q, freq_lock_calibrator_en_q, fail_q}, {5'h01, 2'h0, 2'h0});
    chk(32'(cal_q), 32'(prod_cal));
    reset = 1'b0;
    cyc(3);
    chk(32'(osc_en_q), 32'h01);
    $display("test reset done");
    ulp_req = 1'b1;
    cyc(2);
    chk(32'(osc_en_q.ultra_low_power_osc), 32'h1);
    count_1k(1'b0, n1);
    chk(n1, 4);
    ulp_req = 1'b0;
    rtc_en = 1'b1;
    cyc(2);
    chk(32'(osc_en_q.ultra_low_power_osc), 32'h1);
    // The counter clock follows every ulp edge, and those come every 8 cycles.
    n2 = 0;
    repeat (64) begin
      cyc(1);
      if (rtc_tick_q === 1'b1) n2++;
    end
    chk(n2, 8);
    rtc_en = 1'b0;
    sw_osc_en.rc32k = 1'b1;
    cyc(2);
    chk(32'(osc_en_q.ultra_low_power_osc), 32'h0);
    count_1k(1'b1, n1);
    chk(n1, 4);
    $display("test low rate done");
    sw_osc_en.rc32m = 1'b1;
    cyc(3);
    sw_src_sel = cksc_pkg::SRC_RC32M;
    cyc(1);
    chk({switching_q, cur_src_q}, {1'b1, cksc_pkg::SRC_RC2M});
    wait_src(cksc_pkg::SRC_RC32M);
    // Each cpu tick closes a period holding four fast and two medium ticks.
    {n4, n2, seen} = '0;
    repeat (300) begin
      cyc(1);
      if (per4_tick_q === 1'b1) n4++;
      if (per2_tick_q === 1'b1) n2++;
      if (cpu_tick_q === 1'b1) begin
        if (seen) begin
          chk(n4, 4);
          chk(n2, 2);
        end
        {n4, n2, seen} = {64'd0, 1'b1};
      end
    end
    sw_psc_log = 4'hB;
    cyc(2);
    chk(psc_log_q, 4'hB);
    sw_psc_log = 4'hC;
    cyc(2);
    chk(psc_log_q, 4'hB);
    sw_psc_log = 4'h0;
    sw_pll_fac = 5'h1F;
    cyc(2);
    chk(pll_fac_q, 5'h1F);
    sw_pll_fac = 5'h00;
    cyc(2);
    chk(pll_fac_q, 5'h1F);
    sw_src_sel = cksc_pkg::SRC_XOSC;
    cyc(2);
    chk({switch_refused_q, cur_src_q}, {1'b1, cksc_pkg::SRC_RC32M});
    $display("test switch done");
    xtal_run = 1'b1;
    sw_osc_en.xosc = 1'b1;
    wait_src(cksc_pkg::SRC_XOSC);
    {sw_mon_en, sw_nmi_en} = 2'b11;
    cyc(20);
    nmi_seen = 0;
    xtal_run = 1'b0;
    for (int k = 0; k < 200 && fail_q !== 2'b01; k++) cyc(1);
    cyc(3);
    chk(32'(fail_q), 32'h1);
    chk(nmi_seen, 1);
    chk(32'(cur_src_q), 32'(cksc_pkg::SRC_RC2M));
    chk(32'(switch_refused_q), 32'h1);
    sw_src_sel = cksc_pkg::SRC_RC2M;
    sw_osc_en.xosc = 1'b0;
    sw_fail_clr = 2'b01;
    cyc(1);
    sw_fail_clr = 2'b00;
    {sw_ext_pin_sel, sw_portc_sel, sw_xosc_mode} = {1'b1, 3'h5, 2'h3};
    cyc(2);
    chk({fail_q, ext_pin_sel_q, portc_sel_q, xosc_mode_q}, {2'h0, 1'b1, 3'h5, 2'h3});
    sw_osc_en.xosc = 1'b1;
    cyc(3);
    sw_src_sel = cksc_pkg::SRC_XOSC;
    wait_src(cksc_pkg::SRC_XOSC);
    $display("test failure done");
    sw_cal_wdata = 8'h77;
    sw_cal_we = 3'b100;
    cyc(1);
    sw_cal_we = 3'b000;
    sw_usb_cal_ld = 1'b1;
    cyc(1);
    sw_usb_cal_ld = 1'b0;
    cyc(1);
    chk(cal_q[2], 8'h77);
    chk(cal_q[1], 8'h80);
    // The 2 MHz oscillator and its reference tick together here, so the
    // counted edges stay below target and the byte climbs once per period.
    sw_osc_en.rc2m = 1'b1;
    sw_freq_lock_calibrator_en = 2'b01;
    cyc(2);
    chk(32'(freq_lock_calibrator_en_q), 32'h1);
    sw_cal_wdata = 8'h10;
    sw_cal_we = 3'b001;
    cyc(1);
    sw_cal_we = 3'b000;
    cyc(64);
    sw_freq_lock_calibrator_en = 2'b00;
    chk(cal_q[0], 8'h18);
    sw_osc_en.lfx = 1'b1;
    sw_src_sel = cksc_pkg::SRC_LFX;
    wait_src(cksc_pkg::SRC_LFX);
    $display("test calibration done");
    reset = 1'b1;
    cyc(2);
    chk({osc_en_q, cur_src_q}, {7'h40, cksc_pkg::SRC_RC2M});
    reset = 1'b0;
    cyc(2);
    chk({switching_q, cur_src_q}, {1'b1, cksc_pkg::SRC_RC2M});
    $display("test second reset done");
    stop_test();
  end
endmodule : tb_top
